// file: rtc_control_and_year_alarm.v
`timescale 1ns/1ps
`default_nettype none
`include "rtc_control_and_year_alarm_consts.vh"
module rtc_control_and_year_alarm
(
  // Clock, resets and mode
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire manual_rst_i,
  input wire standby_i,
  // Wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  // Oscillator pin
  input wire osc_i,
  // Time counter side
  input wire [7:0] seconds_i,
  input wire [15:0] year_count_i,
  input wire other_match_i,
  input wire other_enabled_i,
  output reg count_run_o,
  output reg second_tick_o,
  output reg round_down_o,
  output reg round_up_o,
  // Oscillator and interrupt side
  output reg osc_enable_o,
  output reg periodic_request_o,
  output reg alarm_match_flag_o,
  output reg carry_flag_o
);
  // ****************************************
  // Period tap decode
  // ****************************************
  function [15:0] tap_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h1: tap_mask = `MASK_1_256;
        3'h2: tap_mask = `MASK_1_64;
        3'h3: tap_mask = `MASK_1_16;
        3'h4: tap_mask = `MASK_1_4;
        3'h5: tap_mask = `MASK_1_2;
        3'h6: tap_mask = `MASK_1_1;
        3'h7: tap_mask = `MASK_2_1;
        default: tap_mask = 16'h0000;
      endcase
    end
  endfunction

  function wraps;
    input [15:0] cnt;
    input [15:0] mask;
    begin
      wraps = ((cnt & mask) == mask) && (mask != 16'h0000);
    end
  endfunction

  // ****************************************
  // Reset images
  // ****************************************
  localparam [7:0] TWO_RST = `RST_CONTROL_TWO;
  localparam [7:0] THREE_RST = `RST_CONTROL_THREE;
  localparam [2:0] SEL_RST = `RST_SEL;
  localparam FLAG_RST = TWO_RST[`BIT_PERIODIC_FLAG];
  localparam OSC_RST = TWO_RST[`BIT_OSC_ENABLE];
  localparam START_RST = TWO_RST[`BIT_COUNT_START];
  localparam YEAR_CMP_RST = THREE_RST[`BIT_YEAR_COMPARE];

  // ****************************************
  // State
  // ****************************************
  reg periodic_flag_r;
  reg [2:0] period_select_r;
  reg oscillator_enable_r;
  reg count_start_r;
  reg year_compare_on_r;
  reg [15:0] year_alarm_value_r;
  reg carry_flag_r;
  reg alarm_match_flag_r;
  reg div_clear_r;
  reg [31:0] rdata_nxt;

  wire [15:0] div_count;
  wire [15:0] div_prev;
  wire div_step;
  wire access;
  wire wr;
  wire rd;
  wire wr_two;
  wire wr_three;
  wire wr_year;
  wire wr_status;
  wire rd_sixty_four;
  wire round_req;
  wire period_hit;
  wire second_carry;
  wire sixty_four_carry;
  wire year_ok;
  wire alarm_match;

  // ****************************************
  // Divider chain
  // ****************************************
  rtc_divider u_divider
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .osc_i(osc_i),
    .run_i(oscillator_enable_r),
    .clear_i(div_clear_r),
    .count_o(div_count),
    .step_o(div_step)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign access = cyc_i & stb_i & ack_o;
  assign wr = access & we_i & sel_i[0];
  assign rd = cyc_i & stb_i & ~we_i;
  assign wr_two = wr & (adr_i == `OFS_CONTROL_TWO);
  assign wr_three = wr & (adr_i == `OFS_CONTROL_THREE);
  assign wr_year = access & we_i & (adr_i == `OFS_YEAR_ALARM);
  assign wr_status = wr & (adr_i == `OFS_STATUS);
  assign rd_sixty_four = rd & (adr_i == `OFS_SIXTY_FOUR);
  assign round_req = wr_two & dat_i[`BIT_HALF_MINUTE];

  // ****************************************
  // Divider value before the latest step
  // ****************************************
  assign div_prev = div_count - 16'h0001;

  // ****************************************
  // Event detection
  // ****************************************
  assign period_hit = div_step & wraps(div_prev,
    tap_mask(period_select_r));
  assign second_carry = div_step & count_start_r &
    wraps(div_prev, `SECOND_MASK);
  assign sixty_four_carry = div_step & rd_sixty_four &
    wraps(div_prev, `SIXTY_FOUR_STEP_MASK);
  assign year_ok = ~year_compare_on_r |
    (year_count_i == year_alarm_value_r);
  assign alarm_match = other_match_i & year_ok &
    (other_enabled_i | year_compare_on_r);

  // ****************************************
  // Read data
  // ****************************************
  always @*
  begin
    rdata_nxt = 32'h00000000;
    case (adr_i)
      `OFS_CONTROL_TWO:
      begin
        rdata_nxt[`BIT_PERIODIC_FLAG] = periodic_flag_r;
        rdata_nxt[`BIT_SEL_HI:`BIT_SEL_LO] = period_select_r;
        rdata_nxt[`BIT_OSC_ENABLE] = oscillator_enable_r;
        rdata_nxt[`BIT_COUNT_START] = count_start_r;
      end
      `OFS_CONTROL_THREE:
        rdata_nxt[`BIT_YEAR_COMPARE] = year_compare_on_r;
      `OFS_YEAR_ALARM:
        rdata_nxt[15:0] = year_alarm_value_r;
      `OFS_STATUS:
      begin
        rdata_nxt[`BIT_CARRY_FLAG] = carry_flag_r;
        rdata_nxt[`BIT_ALARM_FLAG] = alarm_match_flag_r;
      end
      `OFS_SIXTY_FOUR:
        rdata_nxt[6:0] = div_count[14:8];
      default:
        rdata_nxt = 32'h00000000;
    endcase
  end

  // ****************************************
  // Bus handshake
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= rdata_nxt;
    end
  end

  // ****************************************
  // Control two
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      periodic_flag_r <= FLAG_RST;
      period_select_r <= SEL_RST;
      oscillator_enable_r <= OSC_RST;
      count_start_r <= START_RST;
      div_clear_r <= 1'b0;
    end
    else if (ce_i)
    begin
      div_clear_r <= 1'b0;
      if (manual_rst_i)
      begin
        periodic_flag_r <= FLAG_RST;
        period_select_r <= SEL_RST;
      end
      else if (!standby_i || wr_two)
      begin
        if (wr_two)
        begin
          period_select_r <= dat_i[`BIT_SEL_HI:`BIT_SEL_LO];
          oscillator_enable_r <= dat_i[`BIT_OSC_ENABLE];
          count_start_r <= dat_i[`BIT_COUNT_START];
          div_clear_r <= dat_i[`BIT_DIV_RESET] |
            dat_i[`BIT_HALF_MINUTE];
        end
        if (period_hit || (wr_two && dat_i[`BIT_PERIODIC_FLAG]))
          periodic_flag_r <= 1'b1;
        else if (wr_two)
          periodic_flag_r <= 1'b0;
      end
      else if (period_hit)
        periodic_flag_r <= 1'b1;
    end
  end

  // ****************************************
  // Control three and year alarm
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
      year_compare_on_r <= YEAR_CMP_RST;
    else if (ce_i && wr_three)
      year_compare_on_r <= dat_i[`BIT_YEAR_COMPARE];
  end

  always @(posedge clk_i)
  begin
    if (ce_i && wr_year)
    begin
      if (sel_i[0])
        year_alarm_value_r[7:0] <= dat_i[7:0];
      if (sel_i[1])
        year_alarm_value_r[15:8] <= dat_i[15:8];
    end
  end

  // ****************************************
  // Carry and alarm flags
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      carry_flag_r <= 1'b0;
      alarm_match_flag_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (second_carry || sixty_four_carry ||
          (wr_status && dat_i[`BIT_CARRY_FLAG]))
        carry_flag_r <= 1'b1;
      else if (wr_status)
        carry_flag_r <= 1'b0;
      if (alarm_match)
        alarm_match_flag_r <= 1'b1;
      else if (wr_status && !dat_i[`BIT_ALARM_FLAG])
        alarm_match_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_run_o <= START_RST;
      second_tick_o <= 1'b0;
      round_down_o <= 1'b0;
      round_up_o <= 1'b0;
      osc_enable_o <= OSC_RST;
      periodic_request_o <= 1'b0;
      alarm_match_flag_o <= 1'b0;
      carry_flag_o <= 1'b0;
    end
    else if (ce_i)
    begin
      count_run_o <= count_start_r;
      second_tick_o <= second_carry;
      round_down_o <= round_req & (seconds_i < `HALF_MINUTE_BCD);
      round_up_o <= round_req & (seconds_i >= `HALF_MINUTE_BCD);
      osc_enable_o <= oscillator_enable_r;
      periodic_request_o <= periodic_flag_r &
        (period_select_r != 3'h0);
      alarm_match_flag_o <= alarm_match_flag_r;
      carry_flag_o <= carry_flag_r;
    end
  end
endmodule
`default_nettype wire

// file: rtc_control_and_year_alarm_consts.vh
`ifndef RTC_CONTROL_AND_YEAR_ALARM_CONSTS_VH
`define RTC_CONTROL_AND_YEAR_ALARM_CONSTS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CONTROL_TWO 8'h00
`define OFS_CONTROL_THREE 8'h04
`define OFS_YEAR_ALARM 8'h08
`define OFS_STATUS 8'h0C
`define OFS_SIXTY_FOUR 8'h10
// ****************************************
// Field positions
// ****************************************
`define BIT_PERIODIC_FLAG 7
`define BIT_SEL_HI 6
`define BIT_SEL_LO 4
`define BIT_OSC_ENABLE 3
`define BIT_HALF_MINUTE 2
`define BIT_DIV_RESET 1
`define BIT_COUNT_START 0
`define BIT_YEAR_COMPARE 7
`define BIT_CARRY_FLAG 7
`define BIT_ALARM_FLAG 0
// ****************************************
// Reset values
// ****************************************
`define RST_CONTROL_TWO 8'h09
`define RST_CONTROL_THREE 8'h00
`define RST_SEL 3'h0
// ****************************************
// Timing counts in oscillator edges and the half-minute BCD seconds value
// ****************************************
`define OSC_DIV_WIDTH 16
`define SECOND_MASK 16'h7FFF
`define SIXTY_FOUR_STEP_MASK 16'h00FF
`define MASK_1_256 16'h007F
`define MASK_1_64 16'h01FF
`define MASK_1_16 16'h07FF
`define MASK_1_4 16'h1FFF
`define MASK_1_2 16'h3FFF
`define MASK_1_1 16'h7FFF
`define MASK_2_1 16'hFFFF
`define HALF_MINUTE_BCD 8'h30
`endif

// file: rtc_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "rtc_control_and_year_alarm_consts.vh"
module rtc_divider
(
  // Clock and control
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // Oscillator pin and divider control
  input wire osc_i,
  input wire run_i,
  input wire clear_i,
  // Divider state
  output reg [`OSC_DIV_WIDTH-1:0] count_o,
  output reg step_o
);
  // ****************************************
  // Oscillator synchroniser
  // ****************************************
  reg sync1_r;
  reg sync2_r;
  reg sync3_r;
  reg level_r;
  wire agree;
  wire rise;

  assign agree = (sync2_r == sync3_r);
  assign rise = agree & sync3_r & ~level_r;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_r <= osc_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (agree)
        level_r <= sync3_r;
    end
  end

  // ****************************************
  // Prescaler and 64 Hz chain
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_o <= {`OSC_DIV_WIDTH{1'b0}};
      step_o <= 1'b0;
    end
    else if (ce_i)
    begin
      step_o <= 1'b0;
      if (clear_i)
        count_o <= {`OSC_DIV_WIDTH{1'b0}};
      else if (run_i && rise)
      begin
        count_o <= count_o + 1'b1;
        step_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtc_ctl_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus and control checks
// ****************************************
module rtc_ctl_chk
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Control side
  input wire logic [7:0] seconds_i,
  input wire logic count_run_o,
  input wire logic osc_enable_o,
  input wire logic round_up_o,
  input wire logic round_down_o,
  input wire logic carry_flag_o,
  input wire logic periodic_request_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire ctl_wr = ack_o && we_i && adr_i == 8'h00 && sel_i[0];
  wire rd_ack = ack_o && !we_i;
  property p_ack_answer;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_reset_vals;
    $fell(rst_i) |-> count_run_o && osc_enable_o && !ack_o && !carry_flag_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_hold;
    !(cyc_i && stb_i) && !$past(cyc_i && stb_i) |=> $stable(count_run_o) && $stable(osc_enable_o);
  endproperty
  a_hold: assert property (p_hold) else $error("control bit moved");
  property p_start_wr;
    ctl_wr |-> ##2 count_run_o == $past(dat_i[0], 2) && osc_enable_o == $past(dat_i[3], 2);
  endproperty
  a_start_wr: assert property (p_start_wr) else $error("start or osc wrong");
  property p_ctl2_read;
    rd_ack && adr_i == 8'h00 |-> dat_o[31:8] == 24'h0 && dat_o[2:1] == 2'h0;
  endproperty
  a_ctl2_read: assert property (p_ctl2_read) else $error("control two read");
  property p_ctl3_read;
    rd_ack && adr_i == 8'h04 |-> dat_o[6:0] == 7'h00;
  endproperty
  a_ctl3_read: assert property (p_ctl3_read) else $error("control three read");
  property p_round_up;
    ctl_wr && dat_i[2] && seconds_i >= 8'h30 |-> ##[1:2] round_up_o;
  endproperty
  a_round_up: assert property (p_round_up) else $error("no round up");
  property p_round_dn;
    ctl_wr && dat_i[2] && seconds_i < 8'h30 |-> ##[1:2] round_down_o;
  endproperty
  a_round_dn: assert property (p_round_dn) else $error("no round down");
  property p_carry_set;
    ack_o && we_i && adr_i == 8'h0C && sel_i[0] && dat_i[7] |-> ##[1:2] carry_flag_o;
  endproperty
  a_carry_set: assert property (p_carry_set) else $error("carry not set");
  property p_req_sel;
    ctl_wr && dat_i[6:4] == 3'h0 |-> ##2 !periodic_request_o;
  endproperty
  a_req_sel: assert property (p_req_sel) else $error("request with zero select");
  property p_req_set;
    ctl_wr && dat_i[7] && dat_i[6:4] != 3'h0 |-> ##2 periodic_request_o;
  endproperty
  a_req_set: assert property (p_req_set) else $error("request missing");
endmodule
bind rtc_control_and_year_alarm rtc_ctl_chk u_chk
(
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
  .seconds_i, .count_run_o, .osc_enable_o, .round_up_o, .round_down_o, .carry_flag_o,
  .periodic_request_o
);
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i, rst_i, manual_rst_i, standby_i, cyc_i, stb_i, we_i, osc_run;
  logic other_match_i;
  logic [7:0] adr_i, seconds_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, q, q0;
  logic [15:0] year_count_i;
  logic [2:0] osc_cnt;
  int miscompares, tests_run, ups, downs, c, i;
  wire [31:0] dat_o;
  wire ack_o, count_run_o, second_tick_o, round_down_o, round_up_o;
  wire osc_enable_o, periodic_request_o, alarm_match_flag_o, carry_flag_o;
  wire osc_i = osc_cnt[2];
  wire [2:0] obs = {carry_flag_o, alarm_match_flag_o, periodic_request_o};
  rtc_control_and_year_alarm dut
  (
    .clk_i, .rst_i, .ce_i(1'b1), .manual_rst_i, .standby_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .osc_i, .seconds_i, .year_count_i,
    .other_match_i, .other_enabled_i(1'b0), .count_run_o, .second_tick_o,
    .round_down_o, .round_up_o, .osc_enable_o, .periodic_request_o,
    .alarm_match_flag_o, .carry_flag_o
  );
  // ****************************************
  // Clock, oscillator and pulse counts
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (osc_run)
      osc_cnt <= osc_cnt + 3'h1;
    ups <= ups + round_up_o;
    downs <= downs + round_down_o;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask
  task automatic await(input int k, input logic v, input int n);
    c = 0;
    while (obs[k] !== v && c < n)
    begin
      @(posedge clk_i);
      c++;
    end
    chk(obs[k], v);
    if (obs[k] !== v)
      wrap_up();
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_i = 1'b1;
    manual_rst_i = 1'b0;
    standby_i = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    seconds_i = 8'h45;
    other_match_i = 1'b1;
    year_count_i = 16'h0000;
    osc_cnt = 3'h0;
    osc_run = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h09);
    rd(8'h04, 32'h00);
    wr(8'h20, 32'hFF);
    rd(8'h20, 32'h00);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'h80);
    wb(1'b1, 8'h08, 32'h1999, 4'h3);
    wb(1'b1, 8'h08, 32'h0042, 4'h1);
    rd(8'h08, 32'h1942);
    year_count_i <= 16'h1942;
    await(1, 1'b1, 20);
    wr(8'h0C, 32'h80);
    @(posedge clk_i);
    chk(alarm_match_flag_o, 1'b1);
    await(1, 1'b1, 20);
    await(2, 1'b1, 20);
    year_count_i <= 16'h2000;
    wr(8'h0C, 32'h00);
    await(1, 1'b0, 20);
    await(2, 1'b0, 20);
    other_match_i <= 1'b0;
    year_count_i <= 16'h1942;
    repeat (4) @(posedge clk_i);
    chk(alarm_match_flag_o, 1'b0);
    other_match_i <= 1'b1;
    await(1, 1'b1, 20);
    year_count_i <= 16'h2000;
    wr(8'h0C, 32'h00);
    await(1, 1'b0, 20);
    wr(8'h00, 32'h99);
    await(0, 1'b1, 20);
    wr(8'h00, 32'h89);
    await(0, 1'b0, 20);
    rd(8'h00, 32'h89);
    osc_run <= 1'b1;
    for (i = 1; i < 4; i++)
    begin
      wr(8'h00, 32'h0B | (i << 4));
      await(0, 1'b0, 20);
      await(0, 1'b1, 20000);
      chk((c + 32) / 64, 16 << (2 * i - 2));
    end
    wr(8'h00, 32'h98);
    manual_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    manual_rst_i <= 1'b0;
    rd(8'h00, 32'h08);
    chk(count_run_o, 1'b0);
    standby_i <= 1'b1;
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    q0 = q;
    repeat (2100) @(posedge clk_i);
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    chk(q != q0, 1'b1);
    rd(8'h00, 32'h08);
    standby_i <= 1'b0;
    wr(8'h00, 32'h0A);
    rd(8'h10, 32'h00);
    repeat (2100) @(posedge clk_i);
    osc_run <= 1'b0;
    wr(8'h00, 32'h0D);
    seconds_i <= 8'h29;
    wr(8'h00, 32'h0D);
    rd(8'h00, 32'h09);
    chk(ups, 1);
    chk(downs, 1);
    rd(8'h10, 32'h00);
    wr(8'h00, 32'h03);
    rd(8'h00, 32'h01);
    chk(osc_enable_o, 1'b0);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h08, 32'h1942);
    rd(8'h04, 32'h00);
    rd(8'h00, 32'h09);
    wrap_up();
  end
endmodule
`default_nettype wire
